// File: dv/rtcix_host.sv
// Purpose: host model issuing byte I/O cycles to the index/data ports
// Assumes: strobes one cycle wide, launched just after a rising edge
// Notes:   released write bus shows the inverse of the last byte
`timescale 1ns/1ps
module rtcix_host (
    input  wire logic       mclk,
    output logic [1:0]      io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata
);
    // Idle bus at time zero
    initial begin
        io_addr  = 2'h0;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end
    // One write cycle, values already in BCD or binary as chosen
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge mclk);
        io_wr    <= 1'b0;
        io_wdata <= ~d; // No stale byte left
    endtask
    // One read cycle, byte taken at the edge after the strobe, where it stands
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge mclk);
        io_rd   <= 1'b0;
        @(posedge mclk);
        d = io_rdata;
    endtask
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the indexed clock register block
// Assumes: shortened second of TICK cycles
// Notes:   SET bit freezes time while fields are loaded
`timescale 1ns/1ps
module testbench;
    import rtcix_pkg::*;
    localparam int TICK = 20;   // Cycles per simulated second
    logic       mclk;
    logic       resetn;
    logic [1:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       irq;
    int         err_count;
    int         compares;
    int         cyc;

    rtcix_regs #(.TICK_CNT(TICK)) u_dut (.mclk(mclk), .resetn(resetn), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq));
    rtcix_host u_host (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    // Clock at 20 MHz
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end
    // Byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Lower block register write and read-compare
    task automatic set(input logic [6:0] i, input logic [7:0] d);
        u_host.wr(PORT_IDX_LO, {1'b0, i});
        u_host.wr(PORT_DAT_LO, d);
    endtask
    task automatic get(input logic [6:0] i, input logic [7:0] exp);
        logic [7:0] d;
        u_host.wr(PORT_IDX_LO, {1'b0, i});
        u_host.rd(PORT_DAT_LO, d);
        chk(d, exp);
    endtask
    // Reset values and plain storage of fields 01H-07H
    task automatic t_regs();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) get(7'(i), 8'h00);
        set(IX_CTLB, 8'h80);
        for (int i = 1; i < 8; i++) set(7'(i), 8'(8'h50 + i));
        for (int i = 1; i < 8; i++) get(7'(i), 8'(8'h50 + i));
        set(IX_SEC, 8'hD9);
        get(IX_SEC, 8'h59);
        u_host.rd(PORT_DAT_LO, d);
        chk(d, 8'h59);
        $display("test regs done");
    endtask
    // Two blocks behind two port pairs stay apart
    task automatic t_scratch();
        logic [7:0] d;
        set(7'h10, 8'h3C);
        u_host.wr(PORT_IDX_HI, 8'h10);
        u_host.wr(PORT_DAT_HI, 8'hA5);
        u_host.rd(PORT_DAT_HI, d);
        chk(d, 8'hA5);
        get(7'h10, 8'h3C);
        $display("test scratch done");
    endtask
    // Full rollover of seconds, minutes and hours in one tick
    task automatic t_roll(input logic [7:0] ctl, input logic [7:0] s,
                          input logic [7:0] h, input logic [7:0] hx);
        set(IX_CTLB, ctl | 8'h80);
        set(IX_SEC, s);
        set(IX_MIN, s);
        set(IX_HR, h);
        set(IX_CTLB, ctl);
        repeat (TICK + 4) @(posedge mclk);
        get(IX_SEC, 8'h00);
        get(IX_MIN, 8'h00);
        get(IX_HR, hx);
        $display("test roll ctl=%h done", ctl);
    endtask
    // Rollover at 23:59:59 or 01:59:59: leap day, month end, saving time
    task automatic t_cal(input logic [7:0] ctl, input logic [7:0] yr, input logic [7:0] mo,
                         input logic [7:0] md, input logic [7:0] h, input logic [7:0] hx,
                         input logic [7:0] mdx, input logic [7:0] mox);
        set(IX_CTLB, ctl | 8'h80);
        set(IX_YEAR, yr);
        set(IX_MON, mo);
        set(IX_MDAY, md);
        set(IX_WDAY, 8'h01);
        set(IX_HR, h);
        set(IX_MIN, 8'h59);
        set(IX_SEC, 8'h59);
        set(IX_CTLB, ctl);
        repeat (TICK + 4) @(posedge mclk);
        get(IX_HR, hx);
        get(IX_MDAY, mdx);
        get(IX_MON, mox);
        $display("test cal mon=%h day=%h done", mo, md);
    endtask
    // Alarm with seconds wildcard fires at 00:00:00
    task automatic t_alarm();
        set(IX_CTLB, 8'hA2);
        set(IX_SEC, 8'h59);
        set(IX_MIN, 8'h59);
        set(IX_HR, 8'h23);
        set(IX_SALM, 8'hC0);
        set(IX_MALM, 8'h00);
        set(IX_HALM, 8'h00);
        chk({7'h00, irq}, 8'h00);
        set(IX_CTLB, 8'h22);
        repeat (TICK + 4) @(posedge mclk);
        chk({7'h00, irq}, 8'h01);
        get(IX_STATC, 8'hB0);
        repeat (2) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        $display("test alarm done");
    endtask
    // Counts and verdict
    task automatic finish_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        err_count = 0;
        compares  = 0;
        cyc       = 0;
        resetn    = 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_scratch();
        t_roll(8'h02, 8'h59, 8'h23, 8'h00);
        t_roll(8'h00, 8'h59, 8'h91, 8'h12);
        t_roll(8'h06, 8'h3B, 8'h17, 8'h00);
        t_cal(8'h02, 8'h12, 8'h02, 8'h28, 8'h23, 8'h00, 8'h29, 8'h02);
        t_cal(8'h02, 8'h14, 8'h02, 8'h28, 8'h23, 8'h00, 8'h01, 8'h03);
        t_cal(8'h03, 8'h00, 8'h04, 8'h25, 8'h01, 8'h03, 8'h25, 8'h04);
        t_cal(8'h03, 8'h00, 8'h10, 8'h30, 8'h01, 8'h01, 8'h30, 8'h10);
        t_alarm();
        finish_test();
    end
endmodule

// File: shared/rtcix_pkg.sv
// Purpose: constants for the indexed real-time clock register block
// Assumes: one 20 MHz clock, host I/O strobes on that clock
// Notes:   enc() turns a decimal constant into the active data mode
package rtcix_pkg;
    // Port and data widths
    localparam int PORT_W = 2;
    localparam int DATA_W = 8;
    localparam int IDX_W  = 7;
    localparam int DIV_W  = 32;
    localparam int RAM_DEPTH = 256;

    // Port offsets from the first index port
    localparam logic [1:0] PORT_IDX_LO = 2'h0;
    localparam logic [1:0] PORT_DAT_LO = 2'h1;
    localparam logic [1:0] PORT_IDX_HI = 2'h2;
    localparam logic [1:0] PORT_DAT_HI = 2'h3;

    // Register indices in the lower block
    localparam logic [6:0] IX_SEC   = 7'h00;
    localparam logic [6:0] IX_SALM  = 7'h01;
    localparam logic [6:0] IX_MIN   = 7'h02;
    localparam logic [6:0] IX_MALM  = 7'h03;
    localparam logic [6:0] IX_HR    = 7'h04;
    localparam logic [6:0] IX_HALM  = 7'h05;
    localparam logic [6:0] IX_WDAY  = 7'h06;
    localparam logic [6:0] IX_MDAY  = 7'h07;
    localparam logic [6:0] IX_MON   = 7'h08;
    localparam logic [6:0] IX_YEAR  = 7'h09;
    localparam logic [6:0] IX_CTLB  = 7'h0B;
    localparam logic [6:0] IX_STATC = 7'h0C;

    // Control byte fields
    localparam int B_SET = 7;
    localparam int B_AIE = 5;
    localparam int B_UIE = 4;
    localparam int B_DM  = 2;
    localparam int B_H24 = 1;
    localparam int B_DSE = 0;
    // Status byte fields
    localparam int C_IRQF = 7;
    localparam int C_AF   = 5;
    localparam int C_UF   = 4;
    // Hour and seconds fields
    localparam int PM_BIT  = 7;
    localparam int SEC_RSV = 7;
    localparam logic [1:0] ALM_ANY  = 2'h3;
    localparam logic [1:0] LEAP_MOD = 2'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] NIB_NINE = 4'h9;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONE  = 4'h1;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // One second in cycles of mclk
    localparam int SECOND_NS   = 1_000_000_000;
    localparam int CLK_NS      = 50;
    localparam int TICK_CYCLES = SECOND_NS / CLK_NS;

    // Decimal field limits
    localparam int D_00 = 0;
    localparam int D_01 = 1;
    localparam int D_02 = 2;
    localparam int D_03 = 3;
    localparam int D_04 = 4;
    localparam int D_06 = 6;
    localparam int D_07 = 7;
    localparam int D_09 = 9;
    localparam int D_10 = 10;
    localparam int D_11 = 11;
    localparam int D_12 = 12;
    localparam int D_23 = 23;
    localparam int D_24 = 24;
    localparam int D_25 = 25;
    localparam int D_28 = 28;
    localparam int D_29 = 29;
    localparam int D_30 = 30;
    localparam int D_31 = 31;
    localparam int D_59 = 59;
    localparam int D_99 = 99;

    // Decimal constant in binary or two-digit BCD form
    function automatic logic [7:0] enc(input logic bin, input int dec);
        enc = bin ? 8'(dec) : {4'(dec / 10), 4'(dec % 10)};
    endfunction
endpackage

// File: src/rtcix_regs.sv
// Purpose: time, alarm, calendar and scratch bytes behind indexed ports
// Assumes: host strobes are synchronous to mclk, one cycle each
// Notes:   reads answer one cycle after the strobe on io_rdata
`timescale 1ns/1ps
module rtcix_regs #(
    parameter int unsigned TICK_CNT = rtcix_pkg::TICK_CYCLES
) (
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic [rtcix_pkg::PORT_W-1:0] io_addr,
    input  wire logic                         io_wr,
    input  wire logic                         io_rd,
    input  wire logic [rtcix_pkg::DATA_W-1:0] io_wdata,
    output logic      [rtcix_pkg::DATA_W-1:0] io_rdata,
    output logic                              irq
);
    import rtcix_pkg::*;

    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CNT - 1);

    // Index latches, one per port pair
    logic [IDX_W-1:0] idx_lo_q;
    logic [IDX_W-1:0] idx_hi_q;
    // Time and calendar fields
    logic [7:0]       sec_q;
    logic [7:0]       min_q;
    logic [7:0]       hr_q;
    logic [7:0]       wday_q;
    logic [7:0]       mday_q;
    logic [7:0]       mon_q;
    logic [7:0]       year_q;
    // Alarm fields
    logic [7:0]       salm_q;
    logic [7:0]       malm_q;
    logic [7:0]       halm_q;
    // Control and sticky status
    logic [7:0]       ctlb_q;
    logic             af_q;
    logic             uf_q;
    logic             dst_back_q;
    // Second divider and update pulses
    logic [DIV_W-1:0] div_q;
    logic             tick_q;
    logic             upd_q;
    // Output registers
    logic [7:0]       rdata_q;
    logic             irq_q;
    // Scratch storage, no reset so contents survive
    logic [7:0]       ram_q [0:RAM_DEPTH-1];

    // Decoded strobes
    logic             wr_lo;
    logic             rd_lo;
    logic             wr_hi;
    logic             lo_is_clk;
    logic             step;
    logic             bin;
    logic             h12;
    // Next values from the counting cells
    logic [7:0]       sec_nxt;
    logic [7:0]       min_nxt;
    logic [7:0]       hr_inc;
    logic [7:0]       hr_nxt;
    logic [7:0]       wday_nxt;
    logic [7:0]       mday_nxt;
    logic [7:0]       mon_nxt;
    logic [7:0]       year_nxt;
    logic             sec_wrap;
    logic             min_wrap;
    logic             hr_wrap;
    logic             day_wrap;
    logic             mday_wrap;
    logic             mon_wrap;
    logic [7:0]       hr_cur;
    logic [7:0]       mday_max;
    logic             leap;
    logic             one_am;
    logic             dst_fwd;
    logic             dst_bwd;
    logic             alarm_hit;
    logic             irq_cond;
    logic [7:0]       stat_byte;
    logic [7:0]       rd_mux;

    assign io_rdata = rdata_q;
    assign irq      = irq_q;

    // Port decode
    assign wr_lo = io_wr && io_addr == PORT_DAT_LO;
    assign rd_lo = io_rd && io_addr == PORT_DAT_LO;
    assign wr_hi = io_wr && io_addr == PORT_DAT_HI;
    // Indices that hold clock state instead of scratch
    assign lo_is_clk = idx_lo_q <= IX_YEAR || idx_lo_q == IX_CTLB || idx_lo_q == IX_STATC;
    assign bin  = ctlb_q[B_DM];
    assign h12  = !ctlb_q[B_H24];
    assign step = tick_q && !ctlb_q[B_SET];

    // Index latches change only on their own port
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idx_lo_q <= IX_SEC;
            idx_hi_q <= IX_SEC;
        end else if (io_wr) begin
            if (io_addr == PORT_IDX_LO) begin
                idx_lo_q <= io_wdata[IDX_W-1:0];
            end
            if (io_addr == PORT_IDX_HI) begin
                idx_hi_q <= io_wdata[IDX_W-1:0];
            end
        end
    end

    // One-second divider; held at zero while updates are off
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
            upd_q  <= 1'b0;
        end else begin
            upd_q <= step;
            if (ctlb_q[B_SET]) begin
                div_q  <= '0;
                tick_q <= 1'b0;
            end else if (div_q == TICK_LAST) begin
                div_q  <= '0;
                tick_q <= 1'b1;
            end else begin
                div_q  <= div_q + DIV_W'(1);
                tick_q <= 1'b0;
            end
        end
    end

    // Counting cells for each wrapping field
    rtcix_wrap_inc u_sec (
        .cur (sec_q), .lo (enc(bin, D_00)), .hi (enc(bin, D_59)),
        .bin (bin), .nxt (sec_nxt), .wrap (sec_wrap)
    );
    rtcix_wrap_inc u_min (
        .cur (min_q), .lo (enc(bin, D_00)), .hi (enc(bin, D_59)),
        .bin (bin), .nxt (min_nxt), .wrap (min_wrap)
    );
    rtcix_wrap_inc u_hr (
        .cur (hr_cur), .lo (enc(bin, h12 ? D_01 : D_00)),
        .hi  (enc(bin, h12 ? D_12 : D_23)),
        .bin (bin), .nxt (hr_inc), .wrap (hr_wrap)
    );
    rtcix_wrap_inc u_wday (
        .cur (wday_q), .lo (enc(bin, D_01)), .hi (enc(bin, D_07)),
        .bin (bin), .nxt (wday_nxt), .wrap ()
    );
    rtcix_wrap_inc u_mday (
        .cur (mday_q), .lo (enc(bin, D_01)), .hi (mday_max),
        .bin (bin), .nxt (mday_nxt), .wrap (mday_wrap)
    );
    rtcix_wrap_inc u_mon (
        .cur (mon_q), .lo (enc(bin, D_01)), .hi (enc(bin, D_12)),
        .bin (bin), .nxt (mon_nxt), .wrap (mon_wrap)
    );
    // Year wrap carries nothing further: the calendar spans one century
    rtcix_wrap_inc u_year (
        .cur (year_q), .lo (enc(bin, D_00)), .hi (enc(bin, D_99)),
        .bin (bin), .nxt (year_nxt), .wrap ()
    );

    // Hour step: PM flag toggles at 11, day turns at 11 PM
    always_comb begin
        hr_cur = h12 ? {1'b0, hr_q[6:0]} : hr_q;
        if (h12) begin
            hr_nxt   = {hr_q[PM_BIT] ^ (hr_cur == enc(bin, D_11)), hr_inc[6:0]};
            day_wrap = hr_q[PM_BIT] && hr_cur == enc(bin, D_11);
        end else begin
            hr_nxt   = hr_inc;
            day_wrap = hr_wrap;
        end
    end

    // Month length; every fourth year is leap across the century
    always_comb begin
        if (bin) begin
            leap = year_q[1:0] == LEAP_MOD;
        end else begin
            leap = (2'({year_q[4], 1'b0}) + year_q[1:0]) == LEAP_MOD;
        end
        if (mon_q == enc(bin, D_02)) begin
            mday_max = leap ? enc(bin, D_29) : enc(bin, D_28);
        end else if (mon_q == enc(bin, D_04) || mon_q == enc(bin, D_06) ||
                     mon_q == enc(bin, D_09) || mon_q == enc(bin, D_11)) begin
            mday_max = enc(bin, D_30);
        end else begin
            mday_max = enc(bin, D_31);
        end
    end

    // Daylight saving: last April Sunday skips 2 AM, October repeats 1 AM
    assign one_am  = ctlb_q[B_DSE] && hr_q == enc(bin, D_01) &&
                     wday_q == enc(bin, D_01);
    assign dst_fwd = one_am && mon_q == enc(bin, D_04) &&
                     mday_q >= enc(bin, D_24);
    assign dst_bwd = one_am && mon_q == enc(bin, D_10) &&
                     mday_q >= enc(bin, D_25) && !dst_back_q;

    // Time and calendar: tick update, host write takes precedence
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sec_q      <= RST_BYTE;
            min_q      <= RST_BYTE;
            hr_q       <= RST_BYTE;
            wday_q     <= RST_BYTE;
            mday_q     <= RST_BYTE;
            mon_q      <= RST_BYTE;
            year_q     <= RST_BYTE;
            dst_back_q <= 1'b0;
        end else begin
            if (step) begin
                sec_q <= sec_nxt;
                if (sec_wrap) begin
                    min_q <= min_nxt;
                    if (min_wrap) begin
                        if (dst_fwd) begin
                            hr_q <= enc(bin, D_03);
                        end else if (dst_bwd) begin
                            dst_back_q <= 1'b1;
                        end else begin
                            hr_q <= hr_nxt;
                            if (day_wrap) begin
                                dst_back_q <= 1'b0;
                                wday_q     <= wday_nxt;
                                mday_q     <= mday_nxt;
                                if (mday_wrap) begin
                                    mon_q <= mon_nxt;
                                    if (mon_wrap) begin
                                        year_q <= year_nxt;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            // Host writes; seconds top bit is forced clear
            if (wr_lo) begin
                unique case (idx_lo_q)
                    IX_SEC:  sec_q  <= {1'b0, io_wdata[6:0]};
                    IX_MIN:  min_q  <= io_wdata;
                    IX_HR:   hr_q   <= io_wdata;
                    IX_WDAY: wday_q <= io_wdata;
                    IX_MDAY: mday_q <= io_wdata;
                    IX_MON:  mon_q  <= io_wdata;
                    IX_YEAR: year_q <= io_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Alarm and control bytes, plain read/write
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            salm_q <= RST_BYTE;
            malm_q <= RST_BYTE;
            halm_q <= RST_BYTE;
            ctlb_q <= RST_BYTE;
        end else if (wr_lo) begin
            unique case (idx_lo_q)
                IX_SALM: salm_q <= io_wdata;
                IX_MALM: malm_q <= io_wdata;
                IX_HALM: halm_q <= io_wdata;
                IX_CTLB: ctlb_q <= io_wdata;
                default: ;
            endcase
        end
    end

    // Match is checked on the cycle after each update
    assign alarm_hit = upd_q &&
                       (salm_q[7:6] == ALM_ANY || salm_q == sec_q) &&
                       malm_q == min_q && halm_q == hr_q;

    // Sticky flags; a read of status clears, a new event wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            af_q <= 1'b0;
            uf_q <= 1'b0;
        end else begin
            af_q <= alarm_hit || (af_q && !(rd_lo && idx_lo_q == IX_STATC));
            uf_q <= upd_q || (uf_q && !(rd_lo && idx_lo_q == IX_STATC));
        end
    end

    // Interrupt follows enabled flags one cycle later
    assign irq_cond = (af_q && ctlb_q[B_AIE]) || (uf_q && ctlb_q[B_UIE]);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_cond;
        end
    end

    // Status byte layout
    always_comb begin
        stat_byte         = RST_BYTE;
        stat_byte[C_IRQF] = irq_cond;
        stat_byte[C_AF]   = af_q;
        stat_byte[C_UF]   = uf_q;
    end

    // Scratch bytes: lower block minus clock indices, whole upper block
    always_ff @(posedge mclk) begin
        if (wr_lo && !lo_is_clk) begin
            ram_q[{1'b0, idx_lo_q}] <= io_wdata;
        end else if (wr_hi) begin
            ram_q[{1'b1, idx_hi_q}] <= io_wdata;
        end
    end

    // Read selection by port and latched index
    always_comb begin
        rd_mux = RST_BYTE;
        unique case (io_addr)
            PORT_IDX_LO: rd_mux = {1'b0, idx_lo_q};
            PORT_IDX_HI: rd_mux = {1'b0, idx_hi_q};
            PORT_DAT_HI: rd_mux = ram_q[{1'b1, idx_hi_q}];
            PORT_DAT_LO: begin
                if (!lo_is_clk) begin
                    rd_mux = ram_q[{1'b0, idx_lo_q}];
                end else begin
                    unique case (idx_lo_q)
                        IX_SEC:   rd_mux = sec_q;
                        IX_SALM:  rd_mux = salm_q;
                        IX_MIN:   rd_mux = min_q;
                        IX_MALM:  rd_mux = malm_q;
                        IX_HR:    rd_mux = hr_q;
                        IX_HALM:  rd_mux = halm_q;
                        IX_WDAY:  rd_mux = wday_q;
                        IX_MDAY:  rd_mux = mday_q;
                        IX_MON:   rd_mux = mon_q;
                        IX_YEAR:  rd_mux = year_q;
                        IX_CTLB:  rd_mux = ctlb_q;
                        IX_STATC: rd_mux = stat_byte;
                        default:  rd_mux = RST_BYTE;
                    endcase
                end
            end
        endcase
    end

    // Read data is captured on the strobe and held until the next read
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= RST_BYTE;
        end else if (io_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_hi_write;
        io_wr && io_addr == PORT_DAT_HI ##1 !io_wr ##1
        !io_wr && io_rd && io_addr == PORT_DAT_HI;
    endsequence
    sequence s_sec_roll;
        step && sec_wrap && !io_wr;
    endsequence

    a_sec_top_zero: assert property (!sec_q[SEC_RSV])
        else $error("seconds bit 7 set");
    a_index_load: assert property (io_wr && io_addr == PORT_IDX_LO |=>
        idx_lo_q == $past(io_wdata[IDX_W-1:0]))
        else $error("lower index not loaded");
    a_index_held: assert property (!(io_wr && io_addr == PORT_IDX_LO) |=>
        $stable(idx_lo_q))
        else $error("lower index moved without a write");
    a_hi_index: assert property (io_wr && io_addr == PORT_IDX_HI |=>
        idx_hi_q == $past(io_wdata[IDX_W-1:0]))
        else $error("upper index not loaded");
    a_scratch_back: assert property (s_hi_write |=>
        io_rdata == $past(io_wdata, 3))
        else $error("scratch byte not read back");
    a_min_read: assert property (rd_lo && idx_lo_q == IX_MIN |=>
        io_rdata == $past(min_q))
        else $error("minutes read wrong");
    a_min_roll: assert property (s_sec_roll |=> min_q == $past(min_nxt))
        else $error("minutes did not advance");
    a_any_second: assert property (upd_q && salm_q[7:6] == ALM_ANY &&
        malm_q == min_q && halm_q == hr_q |=> af_q)
        else $error("every-second alarm missed");
    a_alarm_irq: assert property (alarm_hit && ctlb_q[B_AIE] |=> ##1 irq)
        else $error("alarm interrupt not raised");
    a_leap_feb: assert property ((s_sec_roll and (min_wrap && day_wrap && !dst_fwd &&
        leap && mon_q == enc(bin, D_02) && mday_q == enc(bin, D_28))) |=>
        mday_q == enc($past(bin), D_29))
        else $error("leap day skipped");
endmodule

// File: src/rtcix_wrap_inc.sv
// Purpose: one step of a wrapping time field, BCD or binary
// Assumes: cur lies in lo..hi in the selected coding
// Notes:   purely combinational, shared by every counting field
`timescale 1ns/1ps
module rtcix_wrap_inc (
    input  wire logic [7:0] cur,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    input  wire logic       bin,
    output logic [7:0]      nxt,
    output logic            wrap
);
    import rtcix_pkg::*;

    // Wrap at the top, else binary or decimal carry
    always_comb begin
        wrap = (cur == hi);
        if (wrap) begin
            nxt = lo;
        end else if (bin || cur[3:0] != NIB_NINE) begin
            nxt = cur + BYTE_ONE;
        end else begin
            nxt = {cur[7:4] + NIB_ONE, NIB_ZERO};
        end
    end
endmodule
